/* verilog/gedl_decide.sv */
// Purpose: Decides whether an instruction or event in the guest leaves to
//          the hypervisor, and presents the cause and delivery decision
// Assumes: One request per cycle; controls stable while a request is taken
// Notes:   Answer appears one cycle after the request, from flip-flops
`timescale 1ns/1ps
module gedl_decide #(
    parameter int TS_DIV = gedl_pkg::GEDL_TS_DIV
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    // Request
    input  wire logic                    req_valid,
    input  wire gedl_pkg::gedl_kind_t    req_kind,
    input  wire logic                    higher_fault,
    input  wire logic                    guest_entry,
    // Processor state
    input  wire logic [1:0]              current_privilege_level,
    input  wire logic                    system_management_mode,
    input  wire logic                    long_mode,
    input  wire gedl_pkg::gedl_act_t     activity_state,
    // Execution controls
    input  wire logic                    secondary_ctl_en,
    input  wire logic                    pause_exit_en,
    input  wire logic                    loop_exit_en,
    input  wire logic                    mreg_bitmap_en,
    input  wire logic                    perf_read_exit_en,
    input  wire logic                    rand_read_exit_en,
    input  wire logic                    ts_read_exit_en,
    input  wire logic                    ts_with_id_en,
    input  wire logic                    struct_shadow_en,
    input  wire logic                    wbinv_exit_en,
    input  wire logic                    ext_int_exit_en,
    input  wire logic                    nmi_exit_en,
    // Limits and filter fields
    input  wire logic [31:0]             loop_gap_limit,
    input  wire logic [31:0]             loop_window_limit,
    input  wire logic [31:0]             exception_bitmap,
    input  wire logic [31:0]             fault_code_mask_field,
    input  wire logic [31:0]             fault_code_match_field,
    // Operands
    input  wire logic [31:0]             index_register,
    input  wire logic [63:0]             struct_operand,
    input  wire logic [4:0]              exc_vector,
    input  wire logic [31:0]             page_fault_error_code,
    input  wire logic [7:0]              ext_int_vector,
    // Bitmap load ports
    input  wire logic                    mreg_bm_we,
    input  wire logic [1:0]              mreg_bm_sel,
    input  wire logic [12:0]             mreg_bm_idx,
    input  wire logic                    mreg_bm_bit,
    input  wire logic                    shadow_bm_we,
    input  wire logic                    shadow_bm_sel,
    input  wire logic [14:0]             shadow_bm_idx,
    input  wire logic                    shadow_bm_bit,
    // Answer and timestamp interval count
    output logic                         rsp_valid_q,
    output logic                         exit_q,
    output gedl_pkg::gedl_kind_t         cause_q,
    output logic                         deliver_q,
    output logic [7:0]                   deliver_vec_q,
    output logic                         use_link_q,
    output logic                         discard_q,
    output logic [31:0]                  ts_count_q
);
    import gedl_pkg::*;

    // Parameter check
    if (TS_DIV < 1 || TS_DIV > 65536) begin : g_bad_div
        $error("TS_DIV must lie between 1 and 65536");
    end

    // Reset synchroniser
    logic rst_meta_q;
    logic rst_sync_n_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q   <= 1'b0;
            rst_sync_n_q <= 1'b0;
        end else begin
            rst_meta_q   <= 1'b1;
            rst_sync_n_q <= rst_meta_q;
        end
    end

    // Bitmap storage, loaded by the hypervisor side
    logic mreg_bm [4][GEDL_MREG_BITS];
    logic shadow_bm [2][GEDL_CS_BITS];
    always_ff @(posedge clk) begin
        if (mreg_bm_we) begin
            mreg_bm[mreg_bm_sel][mreg_bm_idx] <= mreg_bm_bit;
        end
        if (shadow_bm_we) begin
            shadow_bm[shadow_bm_sel][shadow_bm_idx] <= shadow_bm_bit;
        end
    end

    // Timestamp-rate tick divider and interval counter
    logic [15:0] div_q;
    logic        ts_tick;
    assign ts_tick = (div_q == 16'(TS_DIV - 1));
    always_ff @(posedge clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            div_q      <= 16'h0000;
            ts_count_q <= 32'h0000_0000;
        end else if (ts_tick) begin
            div_q      <= 16'h0000;
            ts_count_q <= ts_count_q + 32'h0000_0001;
        end else begin
            div_q      <= div_q + 16'h0001;
        end
    end

    // Exception bitmap filter with page-fault code matching
    function automatic logic exc_filter(input logic [4:0]  vec,
                                        input logic [31:0] bmap,
                                        input logic [31:0] code,
                                        input logic [31:0] mask,
                                        input logic [31:0] match);
        logic hit;
        hit = bmap[vec];
        if (vec == GEDL_VEC_PF && (code & mask) != match) begin
            hit = ~hit;
        end
        return hit;
    endfunction

    // Effective secondary controls
    logic loop_en;
    logic rand_en;
    logic tsid_en;
    logic shadow_en;
    logic wbinv_en;
    assign loop_en   = secondary_ctl_en & loop_exit_en;
    assign rand_en   = secondary_ctl_en & rand_read_exit_en;
    assign tsid_en   = secondary_ctl_en & ts_with_id_en;
    assign shadow_en = secondary_ctl_en & struct_shadow_en;
    assign wbinv_en  = secondary_ctl_en & wbinv_exit_en;

    // Spin-hint loop tracking state
    logic        seen_q;
    logic [31:0] last_hint_q;
    logic [31:0] loop_start_q;
    logic        priv_zero;
    logic        loop_first;
    logic        window_over;
    logic        hint_zero;
    assign priv_zero   = (current_privilege_level == 2'h0);
    // A hint in the entry cycle itself is the first one after entry
    assign loop_first  = !seen_q || guest_entry ||
                         ((ts_count_q - last_hint_q) > loop_gap_limit);
    assign window_over = (ts_count_q - loop_start_q) > loop_window_limit;
    assign hint_zero   = req_valid && req_kind == GEDL_K_PAUSE && priv_zero &&
                         !higher_fault;

    // Record times of privilege-zero spin-hints; entry forgets history
    always_ff @(posedge clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            seen_q       <= 1'b0;
            last_hint_q  <= 32'h0000_0000;
            loop_start_q <= 32'h0000_0000;
        end else if (hint_zero) begin
            // Recording wins over an entry in the same cycle
            seen_q       <= 1'b1;
            last_hint_q  <= ts_count_q;
            if (loop_first) begin
                loop_start_q <= ts_count_q;
            end
        end else if (guest_entry) begin
            seen_q       <= 1'b0;
        end
    end

    // Model-register index windows and bitmap lookup
    logic       in_lo;
    logic       in_hi;
    logic [1:0] bm_sel;
    logic       mreg_hit;
    logic [31:0] idx_masked;
    assign in_lo      = index_register <= GEDL_LO_WIN_TOP;
    assign in_hi      = index_register >= GEDL_HI_WIN_BASE &&
                        index_register <= GEDL_HI_WIN_TOP;
    assign idx_masked = index_register & GEDL_WIN_MASK;
    assign bm_sel     = in_hi ?
        ((req_kind == GEDL_K_MREG_WR) ? GEDL_BM_WR_HI : GEDL_BM_RD_HI) :
        ((req_kind == GEDL_K_MREG_WR) ? GEDL_BM_WR_LO : GEDL_BM_RD_LO);
    assign mreg_hit   = mreg_bm[bm_sel][idx_masked[12:0]];

    // Control-structure operand checks
    logic cs_upper;
    logic cs_hit;
    assign cs_upper = long_mode ? (|struct_operand[63:15])
                                : (|struct_operand[31:15]);
    assign cs_hit   = shadow_bm[req_kind == GEDL_K_CS_WR]
                               [struct_operand[GEDL_CS_FIELD_MSB:0]];

    // Exit decision for the request in hand
    logic                exit_d;
    logic                deliver_d;
    logic [7:0]          vec_d;
    logic                link_d;
    logic                discard_d;
    gedl_kind_t          cause_d;
    logic                is_instr;
    always_comb begin
        exit_d    = 1'b0;
        deliver_d = 1'b0;
        vec_d     = 8'h00;
        link_d    = 1'b0;
        discard_d = 1'b0;
        cause_d   = req_kind;
        is_instr  = 1'b1;
        case (req_kind)
            GEDL_K_PAUSE: begin
                if (!priv_zero) begin
                    exit_d = pause_exit_en;
                end else if (pause_exit_en) begin
                    exit_d = 1'b1;
                end else if (loop_en) begin
                    exit_d = !loop_first && window_over;
                end else begin
                    exit_d = 1'b0;
                end
            end
            GEDL_K_MREG_RD, GEDL_K_MREG_WR: begin
                exit_d = !mreg_bitmap_en || !(in_lo || in_hi) ||
                         mreg_hit;
            end
            GEDL_K_PMC_RD: exit_d = perf_read_exit_en;
            GEDL_K_RAND_RD: exit_d = rand_en;
            GEDL_K_TS_RD: exit_d = ts_read_exit_en;
            GEDL_K_WBINV: exit_d = wbinv_en;
            GEDL_K_TSID_RD: exit_d = ts_read_exit_en && tsid_en;
            GEDL_K_RESUME: exit_d = system_management_mode;
            GEDL_K_CS_RD, GEDL_K_CS_WR: begin
                exit_d = !shadow_en || cs_upper || cs_hit;
                link_d = !exit_d;
            end
            GEDL_K_EXCEPT: begin
                is_instr  = 1'b0;
                exit_d    = exc_filter(exc_vector, exception_bitmap,
                                       page_fault_error_code,
                                       fault_code_mask_field,
                                       fault_code_match_field);
                deliver_d = !exit_d;
                vec_d     = {3'h0, exc_vector};
            end
            GEDL_K_DF_NEST: begin
                is_instr = 1'b0;
                exit_d   = 1'b1;
                if (exc_filter(exc_vector, exception_bitmap,
                               page_fault_error_code,
                               fault_code_mask_field,
                               fault_code_match_field)) begin
                    cause_d = GEDL_K_EXCEPT;
                end else begin
                    cause_d = GEDL_K_TRIPLE;
                end
            end
            GEDL_K_EXT_INT: begin
                is_instr = 1'b0;
                if (activity_state == GEDL_ACT_SHUTDOWN ||
                    activity_state == GEDL_ACT_WAIT_SU) begin
                    discard_d = 1'b1;
                end else begin
                    exit_d    = ext_int_exit_en;
                    deliver_d = !ext_int_exit_en;
                    vec_d     = ext_int_vector;
                end
            end
            GEDL_K_NMI: begin
                is_instr = 1'b0;
                if (activity_state == GEDL_ACT_WAIT_SU) begin
                    discard_d = 1'b1;
                end else begin
                    exit_d    = nmi_exit_en;
                    deliver_d = !nmi_exit_en;
                    vec_d     = GEDL_VEC_NMI;
                end
            end
            GEDL_K_RESTART: begin
                is_instr  = 1'b0;
                exit_d    = activity_state != GEDL_ACT_WAIT_SU;
                discard_d = !exit_d;
            end
            GEDL_K_STARTUP: begin
                is_instr  = 1'b0;
                exit_d    = activity_state == GEDL_ACT_WAIT_SU;
                discard_d = !exit_d;
            end
            default: begin
                is_instr = 1'b0;
                cause_d  = GEDL_K_NONE;
            end
        endcase
        // A prior fault of higher priority wins over the instruction exit
        if (is_instr && higher_fault) begin
            exit_d = 1'b0;
            link_d = 1'b0;
        end
    end

    // Registered answer, one cycle after the request
    always_ff @(posedge clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            rsp_valid_q   <= 1'b0;
            exit_q        <= 1'b0;
            cause_q       <= GEDL_K_NONE;
            deliver_q     <= 1'b0;
            deliver_vec_q <= 8'h00;
            use_link_q    <= 1'b0;
            discard_q     <= 1'b0;
        end else begin
            rsp_valid_q   <= req_valid;
            exit_q        <= req_valid && exit_d;
            cause_q       <= (req_valid && exit_d) ? cause_d : GEDL_K_NONE;
            deliver_q     <= req_valid && deliver_d;
            deliver_vec_q <= (req_valid && deliver_d) ? vec_d : 8'h00;
            use_link_q    <= req_valid && link_d;
            discard_q     <= req_valid && discard_d;
        end
    end

    // Checks on the answer
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_sync_n_q);

    a_pause_forced: assert property (
        req_valid && req_kind == GEDL_K_PAUSE && priv_zero && pause_exit_en &&
        !higher_fault |=> exit_q && cause_q == GEDL_K_PAUSE)
        else $error("forced spin-hint exit missing");
    a_pause_quiet: assert property (
        req_valid && req_kind == GEDL_K_PAUSE && priv_zero && !pause_exit_en &&
        !loop_en |=> !exit_q)
        else $error("spin-hint exited with controls clear");
    a_pause_upper: assert property (
        req_valid && req_kind == GEDL_K_PAUSE && !priv_zero && !higher_fault
        |=> exit_q == $past(pause_exit_en))
        else $error("spin-hint above level zero wrong");
    a_loop_first: assert property (
        guest_entry ##1 (hint_zero && !guest_entry && !pause_exit_en)
        |=> !exit_q)
        else $error("first spin-hint after entry exited");
    a_sec_gate: assert property (
        req_valid && !secondary_ctl_en &&
        (req_kind == GEDL_K_RAND_RD || req_kind == GEDL_K_WBINV)
        |=> !exit_q)
        else $error("secondary control not gated");
    a_mreg_off: assert property (
        req_valid && req_kind == GEDL_K_MREG_RD && !mreg_bitmap_en &&
        !higher_fault |=> exit_q)
        else $error("model register read did not exit");
    a_tsid_both: assert property (
        req_valid && req_kind == GEDL_K_TSID_RD && !higher_fault
        |=> exit_q == ($past(ts_read_exit_en) && $past(tsid_en)))
        else $error("timestamp with id decision wrong");
    a_cs_link: assert property (
        use_link_q |-> $past(req_kind) inside {GEDL_K_CS_RD, GEDL_K_CS_WR}
        && !exit_q)
        else $error("link access without structure op");
    a_ext_block: assert property (
        req_valid && req_kind == GEDL_K_EXT_INT &&
        activity_state == GEDL_ACT_SHUTDOWN
        |=> discard_q && !exit_q && !deliver_q)
        else $error("external interrupt not blocked");
    a_nmi_vec: assert property (
        deliver_q && $past(req_kind) == GEDL_K_NMI |-> deliver_vec_q == 8'h02)
        else $error("nonmaskable interrupt vector wrong");
    a_startup: assert property (
        req_valid && req_kind == GEDL_K_STARTUP &&
        activity_state != GEDL_ACT_WAIT_SU |=> discard_q && !exit_q)
        else $error("startup interrupt not discarded");
    a_fault_wins: assert property (
        req_valid && higher_fault && req_kind == GEDL_K_PMC_RD |=> !exit_q)
        else $error("exit taken over higher fault");

    c_loop_exit: cover property (hint_zero && loop_en ##1 exit_q);
    c_triple: cover property (exit_q && cause_q == GEDL_K_TRIPLE);
    c_pf_inv: cover property (req_valid && req_kind == GEDL_K_EXCEPT &&
                              exc_vector == GEDL_VEC_PF ##1 deliver_q);
    c_link: cover property (use_link_q);

endmodule // gedl_decide

/* verilog/gedl_pkg.sv */
// Purpose: Shared constants and types for the guest exit decision logic
// Assumes: Core clock of 200 MHz, one decision request per cycle at most
// Notes:   Event kinds double as the exit cause code presented to software
package gedl_pkg;

    // Event and instruction kinds, also used as the exit cause
    typedef enum logic [4:0] {
        GEDL_K_NONE    = 5'h00,
        GEDL_K_PAUSE   = 5'h01,
        GEDL_K_MREG_RD = 5'h02,
        GEDL_K_MREG_WR = 5'h03,
        GEDL_K_PMC_RD  = 5'h04,
        GEDL_K_RAND_RD = 5'h05,
        GEDL_K_TS_RD   = 5'h06,
        GEDL_K_TSID_RD = 5'h07,
        GEDL_K_RESUME  = 5'h08,
        GEDL_K_WBINV   = 5'h09,
        GEDL_K_CS_RD   = 5'h0A,
        GEDL_K_CS_WR   = 5'h0B,
        GEDL_K_EXCEPT  = 5'h0C,
        GEDL_K_DF_NEST = 5'h0D,
        GEDL_K_EXT_INT = 5'h0E,
        GEDL_K_NMI     = 5'h0F,
        GEDL_K_RESTART = 5'h10,
        GEDL_K_STARTUP = 5'h11,
        GEDL_K_TRIPLE  = 5'h12
    } gedl_kind_t;

    // Activity states of the logical processor
    typedef enum logic [1:0] {
        GEDL_ACT_ACTIVE   = 2'h0,
        GEDL_ACT_HALT     = 2'h1,
        GEDL_ACT_SHUTDOWN = 2'h2,
        GEDL_ACT_WAIT_SU  = 2'h3
    } gedl_act_t;

    // Model-register bitmap selectors
    localparam logic [1:0]  GEDL_BM_RD_LO      = 2'h0;
    localparam logic [1:0]  GEDL_BM_WR_LO      = 2'h1;
    localparam logic [1:0]  GEDL_BM_RD_HI      = 2'h2;
    localparam logic [1:0]  GEDL_BM_WR_HI      = 2'h3;

    // Model-register index windows
    localparam logic [31:0] GEDL_LO_WIN_BASE   = 32'h0000_0000;
    localparam logic [31:0] GEDL_LO_WIN_TOP    = 32'h0000_1FFF;
    localparam logic [31:0] GEDL_HI_WIN_BASE   = 32'hC000_0000;
    localparam logic [31:0] GEDL_HI_WIN_TOP    = 32'hC000_1FFF;
    localparam logic [31:0] GEDL_WIN_MASK      = 32'h0000_1FFF;
    localparam int          GEDL_MREG_BITS     = 8192;

    // Control-structure operand layout
    localparam int          GEDL_CS_FIELD_MSB  = 14;
    localparam int          GEDL_CS_BITS       = 32768;

    // Fixed vectors
    localparam logic [4:0]  GEDL_VEC_PF        = 5'h0E;
    localparam logic [7:0]  GEDL_VEC_NMI       = 8'h02;

    // Divider for the timestamp rate: core cycles per timestamp tick
    localparam int          GEDL_TS_DIV        = 1;
    localparam int          GEDL_TS_W          = 32;

endpackage

/* testbench/test_guest_exit_decision_logic.sv */
// Purpose: Self-checking bench for the guest exit decision logic
// Assumes: Inputs change on the falling edge, answer one cycle later
// Notes:   Table rows cover plain controls; hand tests cover the rest
`timescale 1ns/1ps
module test_guest_exit_decision_logic;
    import gedl_pkg::*;
    // Row: kind, activity, controls, expected exit/deliver/discard/link
    typedef struct packed {
        logic [4:0]  k;
        logic [1:0]  a;
        logic [11:0] c;
        logic [3:0]  e;
    } gedl_row_t;
    logic        clk = 1'b0, reset_n = 1'b0, req_valid = 1'b0;
    logic        higher_fault = 1'b0, guest_entry = 1'b0;
    logic        system_management_mode = 1'b0, long_mode = 1'b1;
    logic        secondary_ctl_en, pause_exit_en, loop_exit_en;
    logic        mreg_bitmap_en, perf_read_exit_en, rand_read_exit_en;
    logic        ts_read_exit_en, ts_with_id_en, struct_shadow_en;
    logic        wbinv_exit_en, ext_int_exit_en, nmi_exit_en;
    logic        mreg_bm_we = 1'b0, mreg_bm_bit = 1'b0;
    logic        shadow_bm_we = 1'b0, shadow_bm_sel = 1'b0;
    logic        shadow_bm_bit = 1'b0;
    logic        rsp_valid_q, exit_q, deliver_q, use_link_q, discard_q;
    logic [1:0]  current_privilege_level = 2'h3, mreg_bm_sel = 2'h0;
    logic [4:0]  exc_vector = 5'h03;
    logic [7:0]  ext_int_vector = 8'h20, deliver_vec_q;
    logic [11:0] ctl = 12'h000;
    logic [12:0] mreg_bm_idx = 13'h0000;
    logic [14:0] shadow_bm_idx = 15'h0000;
    logic [31:0] loop_gap_limit = 32'h0000_0003;
    logic [31:0] loop_window_limit = 32'h0000_000A;
    logic [31:0] index_register = 32'h0000_0000, ts_count_q, t0;
    logic [31:0] exception_bitmap = 32'h0000_0000;
    logic [31:0] fault_code_mask_field = 32'h0000_00FF;
    logic [31:0] fault_code_match_field = 32'h0000_0013;
    logic [31:0] page_fault_error_code = 32'h0000_0000;
    logic [63:0] struct_operand = 64'h0000_0000_0000_0000;
    gedl_kind_t  req_kind = GEDL_K_NONE, cause_q;
    gedl_act_t   activity_state = GEDL_ACT_ACTIVE;
    int          n_errors = 0, n_compared = 0, cyc = 0;
    wire [17:0]  seen = {rsp_valid_q, exit_q, deliver_q, discard_q,
                         use_link_q, cause_q, deliver_vec_q};
    gedl_row_t   rows [26] = '{
        '{5'h00, 2'h0, 12'hFFF, 4'h0}, '{5'h01, 2'h0, 12'h400, 4'h8},
        '{5'h01, 2'h0, 12'hA00, 4'h0}, '{5'h04, 2'h0, 12'h080, 4'h8},
        '{5'h04, 2'h0, 12'hF7F, 4'h0}, '{5'h05, 2'h0, 12'h840, 4'h8},
        '{5'h05, 2'h0, 12'h040, 4'h0}, '{5'h06, 2'h0, 12'h020, 4'h8},
        '{5'h06, 2'h0, 12'hFDF, 4'h0}, '{5'h07, 2'h0, 12'h830, 4'h8},
        '{5'h07, 2'h0, 12'h820, 4'h0}, '{5'h07, 2'h0, 12'h810, 4'h0},
        '{5'h07, 2'h0, 12'h030, 4'h0}, '{5'h09, 2'h0, 12'h804, 4'h8},
        '{5'h09, 2'h0, 12'h004, 4'h0}, '{5'h0E, 2'h0, 12'h002, 4'h8},
        '{5'h0E, 2'h1, 12'h000, 4'h4}, '{5'h0E, 2'h2, 12'h002, 4'h2},
        '{5'h0E, 2'h3, 12'h000, 4'h2}, '{5'h0F, 2'h0, 12'h001, 4'h8},
        '{5'h0F, 2'h2, 12'h000, 4'h4}, '{5'h0F, 2'h3, 12'h001, 4'h2},
        '{5'h10, 2'h1, 12'h000, 4'h8}, '{5'h10, 2'h3, 12'hFFF, 4'h2},
        '{5'h11, 2'h3, 12'h000, 4'h8}, '{5'h11, 2'h0, 12'h000, 4'h2}
    };

    // Control bits in table order
    assign {secondary_ctl_en, pause_exit_en, loop_exit_en, mreg_bitmap_en,
            perf_read_exit_en, rand_read_exit_en, ts_read_exit_en,
            ts_with_id_en, struct_shadow_en, wbinv_exit_en,
            ext_int_exit_en, nmi_exit_en} = ctl;

    gedl_decide #(.TS_DIV(1)) DUT (.*);

    // Core clock, 5 ns period
    always #2.5 clk = ~clk;

    // Cuts a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_errors++;
            give_verdict();
        end
    end

    task automatic chk(input logic [17:0] s, input logic [17:0] x);
        n_compared++;
        if (s !== x) begin
            n_errors++;
            $display("BAD t=%0t seen %h want %h", $time, s, x);
        end
    endtask

    // One request, answer checked one cycle later
    task automatic go(input gedl_kind_t k, input logic [3:0] e);
        gedl_kind_t c;
        logic [7:0] v;
        c = e[3] ? k : GEDL_K_NONE;
        if (k == GEDL_K_DF_NEST)
            c = exception_bitmap[exc_vector] ? GEDL_K_EXCEPT : GEDL_K_TRIPLE;
        v = (k == GEDL_K_EXT_INT) ? ext_int_vector : {3'h0, exc_vector};
        if (k == GEDL_K_NMI)
            v = GEDL_VEC_NMI;
        if (!e[2])
            v = 8'h00;
        req_kind = k;
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        chk(seen, {1'b1, e, c, v});
        @(negedge clk);
    endtask

    task automatic gi(input gedl_kind_t k, input logic [63:0] x,
                      input logic [3:0] e);
        index_register = x[31:0];
        struct_operand = x;
        go(k, e);
    endtask

    task automatic gx(input gedl_kind_t k, input logic [4:0] v,
                      input logic [31:0] b, input logic [31:0] c,
                      input logic [3:0] e);
        exc_vector = v;
        exception_bitmap = b;
        page_fault_error_code = c;
        go(k, e);
    endtask

    // Loads one bitmap bit, shadow map when s is set
    task automatic bm(input logic s, input logic [1:0] sel,
                      input logic [14:0] i, input logic b);
        mreg_bm_we = !s;
        shadow_bm_we = s;
        mreg_bm_sel = sel;
        shadow_bm_sel = sel[0];
        mreg_bm_idx = i[12:0];
        shadow_bm_idx = i;
        mreg_bm_bit = b;
        shadow_bm_bit = b;
        @(negedge clk);
        mreg_bm_we = 1'b0;
        shadow_bm_we = 1'b0;
        @(negedge clk);
    endtask

    task automatic give_verdict();
        if (n_errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (16) @(negedge clk);
        chk(seen, 18'h0_0000);
        reset_n = 1'b1;
        repeat (3) @(negedge clk);
        foreach (rows[i]) begin
            activity_state = gedl_act_t'(rows[i].a);
            ctl = rows[i].c;
            go(gedl_kind_t'(rows[i].k), rows[i].e);
        end
        activity_state = GEDL_ACT_ACTIVE;
        current_privilege_level = 2'h0;
        ctl = 12'hE00;
        go(GEDL_K_PAUSE, 4'h8);
        ctl = 12'h000;
        go(GEDL_K_PAUSE, 4'h0);
        ctl = 12'h200;
        go(GEDL_K_PAUSE, 4'h0);
        ctl = 12'hA00;
        guest_entry = 1'b1;
        @(negedge clk);
        guest_entry = 1'b0;
        for (int k = 0; k < 7; k++)
            go(GEDL_K_PAUSE, {k == 6, 3'h0});
        repeat (3) @(negedge clk);
        go(GEDL_K_PAUSE, 4'h0);
        t0 = ts_count_q;
        @(negedge clk);
        chk(18'(ts_count_q - t0), 18'h0_0001);
        for (int s = 0; s < 4; s++)
            bm(1'b0, 2'(s), 15'h1FFF, s == 0 || s == 3);
        ctl = 12'h100;
        gi(GEDL_K_MREG_RD, 64'h0000_1FFF, 4'h8);
        gi(GEDL_K_MREG_WR, 64'h0000_1FFF, 4'h0);
        gi(GEDL_K_MREG_RD, 64'hC000_1FFF, 4'h0);
        gi(GEDL_K_MREG_WR, 64'hC000_1FFF, 4'h8);
        gi(GEDL_K_MREG_RD, 64'h0000_2000, 4'h8);
        gi(GEDL_K_MREG_WR, 64'hBFFF_FFFF, 4'h8);
        ctl = 12'h000;
        gi(GEDL_K_MREG_RD, 64'hC000_1FFF, 4'h8);
        bm(1'b1, 2'h0, 15'h7FFF, 1'b1);
        bm(1'b1, 2'h1, 15'h7FFF, 1'b0);
        ctl = 12'h808;
        gi(GEDL_K_CS_RD, 64'h7FFF, 4'h8);
        gi(GEDL_K_CS_WR, 64'h7FFF, 4'h1);
        gi(GEDL_K_CS_WR, 64'h0000_0001_0000_7FFF, 4'h8);
        gi(GEDL_K_CS_WR, 64'hFFFF, 4'h8);
        long_mode = 1'b0;
        gi(GEDL_K_CS_WR, 64'h0000_0001_0000_7FFF, 4'h1);
        higher_fault = 1'b1;
        gi(GEDL_K_CS_RD, 64'h7FFF, 4'h0);
        ctl = 12'h080;
        go(GEDL_K_PMC_RD, 4'h0);
        ctl = 12'h002;
        go(GEDL_K_EXT_INT, 4'h8);
        higher_fault = 1'b0;
        ctl = 12'h008;
        gi(GEDL_K_CS_WR, 64'h7FFF, 4'h8);
        system_management_mode = 1'b1;
        go(GEDL_K_RESUME, 4'h8);
        system_management_mode = 1'b0;
        go(GEDL_K_RESUME, 4'h0);
        gx(GEDL_K_EXCEPT, 5'h03, 32'h0000_4008, 32'h0, 4'h8);
        gx(GEDL_K_EXCEPT, 5'h1F, 32'h0000_4008, 32'h0, 4'h4);
        gx(GEDL_K_EXCEPT, 5'h0E, 32'h0000_4008, 32'h1234_5613,
           4'h8);
        gx(GEDL_K_EXCEPT, 5'h0E, 32'h0000_4008, 32'h0000_0012,
           4'h4);
        gx(GEDL_K_EXCEPT, 5'h0E, 32'h0000_0008, 32'h0000_0012,
           4'h8);
        gx(GEDL_K_DF_NEST, 5'h03, 32'h0000_0008, 32'h0, 4'h8);
        gx(GEDL_K_DF_NEST, 5'h05, 32'h0000_0008, 32'h0, 4'h8);
        // Mid-run reset clears answers and counter, bitmaps survive
        reset_n = 1'b0;
        @(negedge clk);
        chk(seen, 18'h0_0000);
        chk(18'(ts_count_q), 18'h0_0000);
        reset_n = 1'b1;
        repeat (3) @(negedge clk);
        ctl = 12'h100;
        gi(GEDL_K_MREG_RD, 64'h0000_1FFF, 4'h8);
        give_verdict();
    end
endmodule // test_guest_exit_decision_logic
